// ---- core/adsb_regs.vh ----
// constants for the converter sequencer, sample buffer and digital monitor
`ifndef ADSB_REGS_VH
`define ADSB_REGS_VH
// clock division: 16 MHz in, selectable 2/1/0.5/0.25 MHz out
`define ADSB_IN_CLK_HZ      16000000
`define ADSB_DIV_2MHZ       2'h0
`define ADSB_DIV_1MHZ       2'h1
`define ADSB_DIV_500KHZ     2'h2
`define ADSB_DIV_250KHZ     2'h3
`define ADSB_HALF_2MHZ      6'h04
`define ADSB_HALF_1MHZ      6'h08
`define ADSB_HALF_500KHZ    6'h10
`define ADSB_HALF_250KHZ    6'h20
// sample period codes and conversion length
`define ADSB_SAMPLE_DEFAULT 2'h0
`define ADSB_CONV_MUL       6'h03
`define ADSB_CONV_ADD       6'h0D
// accumulation counts
`define ADSB_ACC_2          2'h0
`define ADSB_ACC_16         2'h3
// buffer
`define ADSB_BUF_MAX_WORDS  11'h7FF
`define ADSB_CHANNELS       8
// monitor conditions
`define ADSB_MON_BELOW      2'h0
`define ADSB_MON_ABOVE      2'h1
`define ADSB_MON_INSIDE     2'h2
`define ADSB_MON_OUTSIDE    2'h3
// supply monitor channel index
`define ADSB_CH_SUPPLY      3'h7
`endif

// ---- core/adsb_fifo.v ----
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module adsb_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage
  reg [AW-1:0]    wr_ptr;          // write index
  reg [AW-1:0]    rd_ptr;          // read index
  reg [AW:0]      count;           // words held
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointers wrap at depth, so depth need not be a power of two
  always @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // adsb_fifo

// ---- core/adsb_ctrl.v ----
// converter sequencer with accumulator, sample buffer DMA and digital monitor
`timescale 1ns/10ps
`include "adsb_regs.vh"
module adsb_ctrl #(
  parameter AWID      = 11,
  parameter FIFO_DEPTH = 8
) (
  // clock and reset (16 MHz input domain)
  input  wire            clk,
  input  wire            reset_n,
  // configuration
  input  wire [1:0]      clk_div_sel,
  input  wire [1:0]      sample_sel,
  input  wire            gain_sel,
  input  wire            continuous,
  input  wire            start,
  input  wire            acc_enable,
  input  wire [1:0]      acc_count_sel,
  input  wire            acc_defer_irq,
  input  wire [2:0]      single_channel,
  // sample buffer configuration
  input  wire            buf_mode,
  input  wire [7:0]      buf_channel_mask,
  input  wire [15:0]     trigger_period,
  input  wire [AWID-1:0] buf_length,
  input  wire            buf_wrap,
  input  wire            irq_half_en,
  input  wire            irq_full_en,
  input  wire            irq_ovf_en,
  // monitor configuration
  input  wire [9:0]      monitor_upper_limit,
  input  wire [9:0]      monitor_lower_limit,
  input  wire [1:0]      monitor_mode,
  input  wire            monitor_irq_en,
  input  wire            monitor_pin_en,
  // analog core
  output reg             adc_clk,
  output reg             sample_hold,
  output reg             convert_active,
  output reg  [2:0]      channel_sel,
  output reg             gain,
  output reg             supply_div_en,
  input  wire [9:0]      analog_result,
  // dma write port to ram
  output reg             dma_valid,
  input  wire            dma_ready,
  output reg  [AWID-1:0] dma_addr,
  output reg  [15:0]     dma_data,
  // status and events
  output reg  [9:0]      conversion_result,
  output reg  [13:0]     acc_sum,
  output reg             conv_done,
  output reg             conv_irq,
  output reg             buf_half_irq,
  output reg             buf_full_irq,
  output reg             buf_ovf_irq,
  output reg             monitor_irq,
  output reg             monitor_output_pin,
  output reg             busy
);
  // sequencer states
  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;
  localparam ST_DONE   = 2'h3;

  reg  [1:0]      state;          // sequencer state
  reg  [5:0]      div_cnt;        // clock divider count
  reg  [5:0]      half_period;    // selected half period
  reg             adc_tick;       // adc clock rising-edge strobe
  reg  [5:0]      period_cnt;     // adc periods since sampling began
  reg  [4:0]      acc_left;       // samples left in accumulation
  reg  [15:0]     trig_cnt;       // trigger timer
  reg  [7:0]      pend_mask;      // channels still due this trigger
  reg  [AWID-1:0] wr_ptr;         // buffer write pointer
  reg             buf_active;     // buffer run in progress
  reg             conv_is_buf;    // current conversion feeds buffer
  reg             run_req;        // software run request
  reg             mon_hit;        // monitor condition
  wire [3:0]      sample_len;     // sample window in adc clocks
  wire [5:0]      conv_len;       // full conversion in adc clocks
  wire [4:0]      acc_total;      // samples per accumulation
  wire            fifo_in_ready;
  wire            fifo_out_valid;
  wire [AWID+15:0] fifo_out_data;
  reg             fifo_push;
  reg  [AWID+15:0] fifo_in_data;

  // first set channel in a mask, low index first
  function [3:0] first_ch;
    input [7:0] m;
    integer i;
    begin
      first_ch = 4'h8;
      for (i = 7; i >= 0; i = i - 1) begin
        if (m[i]) first_ch = i[3:0];
      end
    end
  endfunction

  // monitor condition for one result
  function mon_eval;
    input [9:0] v;
    input [9:0] up;
    input [9:0] lo;
    input [1:0] md;
    begin
      case (md)
        `ADSB_MON_BELOW:  mon_eval = (v < lo);
        `ADSB_MON_ABOVE:  mon_eval = (v > up);
        `ADSB_MON_INSIDE: mon_eval = (v >= lo) && (v <= up);
        default:          mon_eval = (v < lo) || (v > up);
      endcase
    end
  endfunction

  wire [3:0] scan_ch = first_ch(pend_mask); // lowest pending buffer channel
  assign sample_len = {1'b0, sample_sel, 1'b0} + 4'h2;
  assign conv_len   = `ADSB_CONV_MUL * {2'h0, sample_len} + `ADSB_CONV_ADD;
  assign acc_total  = 5'h2 << acc_count_sel;

  // divider half period from selection
  always @* begin
    case (clk_div_sel)
      `ADSB_DIV_2MHZ:   half_period = `ADSB_HALF_2MHZ;
      `ADSB_DIV_1MHZ:   half_period = `ADSB_HALF_1MHZ;
      `ADSB_DIV_500KHZ: half_period = `ADSB_HALF_500KHZ;
      default:          half_period = `ADSB_HALF_250KHZ;
    endcase
  end

  // adc clock divider; tick marks each rising edge for the sequencer
  always @(posedge clk) begin
    if (!reset_n) begin
      div_cnt  <= 6'h00;
      adc_clk  <= 1'b0;
      adc_tick <= 1'b0;
    end else begin
      adc_tick <= 1'b0;
      if (div_cnt >= half_period - 6'h01) begin
        div_cnt  <= 6'h00;
        adc_clk  <= ~adc_clk;
        adc_tick <= ~adc_clk;
      end else begin
        div_cnt <= div_cnt + 6'h01;
      end
    end
  end

  // buffered dma writes; fifo back-pressure stalls the sequencer in ST_DONE
  adsb_fifo #(
    .WIDTH (AWID + 16),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (~dma_valid | dma_ready),
    .out_data  (fifo_out_data)
  );

  // dma output stage, registered
  always @(posedge clk) begin
    if (!reset_n) begin
      dma_valid <= 1'b0;
      dma_addr  <= {AWID{1'b0}};
      dma_data  <= 16'h0000;
    end else if (~dma_valid | dma_ready) begin
      dma_valid <= fifo_out_valid;
      dma_addr  <= fifo_out_data[AWID+15:16];
      dma_data  <= fifo_out_data[15:0];
    end
  end

  // main sequencer: trigger timer, channel scan, conversion, result handling
  always @(posedge clk) begin
    if (!reset_n) begin
      state              <= ST_IDLE;
      period_cnt         <= 6'h00;
      sample_hold        <= 1'b0;
      convert_active     <= 1'b0;
      channel_sel        <= 3'h0;
      gain               <= 1'b0;
      supply_div_en      <= 1'b0;
      conversion_result  <= 10'h000;
      acc_sum            <= 14'h0000;
      acc_left           <= 5'h00;
      conv_done          <= 1'b0;
      conv_irq           <= 1'b0;
      buf_half_irq       <= 1'b0;
      buf_full_irq       <= 1'b0;
      buf_ovf_irq        <= 1'b0;
      monitor_irq        <= 1'b0;
      monitor_output_pin <= 1'b0;
      mon_hit            <= 1'b0;
      trig_cnt           <= 16'h0000;
      pend_mask          <= 8'h00;
      wr_ptr             <= {AWID{1'b0}};
      buf_active         <= 1'b0;
      conv_is_buf        <= 1'b0;
      run_req            <= 1'b0;
      fifo_push          <= 1'b0;
      fifo_in_data       <= {(AWID+16){1'b0}};
      busy               <= 1'b0;
    end else begin
      // one-cycle pulses default low
      conv_irq     <= 1'b0;
      buf_half_irq <= 1'b0;
      buf_full_irq <= 1'b0;
      buf_ovf_irq  <= 1'b0;
      monitor_irq  <= 1'b0;
      fifo_push    <= 1'b0;
      gain         <= gain_sel;
      if (start) run_req <= 1'b1;
      // software start clears the done flag, but a completion in the same cycle wins
      if (start && state != ST_DONE) conv_done <= 1'b0;
      // trigger timer for buffer mode
      if (buf_mode) begin
        if (trig_cnt >= trigger_period) begin
          trig_cnt  <= 16'h0000;
          pend_mask <= pend_mask | buf_channel_mask;
        end else begin
          trig_cnt <= trig_cnt + 16'h0001;
        end
        if (!buf_active) begin
          buf_active <= 1'b1;
          wr_ptr     <= {AWID{1'b0}};
        end
      end else begin
        trig_cnt   <= 16'h0000;
        pend_mask  <= 8'h00;
        buf_active <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          // buffer scan runs only in buffer mode; software requests are served only outside it
          if (buf_mode && pend_mask != 8'h00 && adc_tick) begin
            channel_sel <= scan_ch[2:0];
            pend_mask[scan_ch[2:0]] <= 1'b0;
            conv_is_buf <= 1'b1;
            supply_div_en <= (scan_ch[2:0] == `ADSB_CH_SUPPLY);
            state       <= ST_SAMPLE;
            period_cnt  <= 6'h00;
            sample_hold <= 1'b1;
            busy        <= 1'b1;
          end else if (!buf_mode && (run_req || start) && adc_tick) begin
            run_req     <= 1'b0;
            channel_sel <= single_channel;
            conv_is_buf <= 1'b0;
            supply_div_en <= (single_channel == `ADSB_CH_SUPPLY);
            state       <= ST_SAMPLE;
            period_cnt  <= 6'h00;
            sample_hold <= 1'b1;
            busy        <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          // sampling, then hold for the remaining conversion clocks
          if (adc_tick) begin
            period_cnt <= period_cnt + 6'h01;
            if (period_cnt + 6'h01 == {2'h0, sample_len}) begin
              sample_hold    <= 1'b0;
              convert_active <= 1'b1;
              state          <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          if (adc_tick) begin
            period_cnt <= period_cnt + 6'h01;
            if (period_cnt + 6'h01 == conv_len) begin
              convert_active    <= 1'b0;
              supply_div_en     <= 1'b0;
              conversion_result <= analog_result;
              mon_hit <= mon_eval(analog_result, monitor_upper_limit,
                                  monitor_lower_limit, monitor_mode);
              state             <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // buffer conversions stall here while the fifo is full
          if (!conv_is_buf || fifo_in_ready) begin
            conv_done <= 1'b1;
            state     <= ST_IDLE;
            busy      <= 1'b0;
            monitor_output_pin <= monitor_pin_en & mon_hit;
            if (monitor_irq_en && mon_hit) monitor_irq <= 1'b1;
            // accumulation period; restart clears the sum
            if (acc_enable) begin
              if (acc_left == 5'h00 || acc_left == 5'h01) begin
                acc_sum  <= (acc_left == 5'h00) ? {4'h0, conversion_result}
                            : acc_sum + {4'h0, conversion_result};
              end else begin
                acc_sum <= acc_sum + {4'h0, conversion_result};
              end
              if (acc_left == 5'h01) begin
                acc_left <= 5'h00;
                conv_irq <= 1'b1;
              end else begin
                acc_left <= (acc_left == 5'h00) ? acc_total - 5'h01 : acc_left - 5'h01;
                conv_irq <= ~acc_defer_irq;
              end
            end else begin
              acc_left <= 5'h00;
              conv_irq <= 1'b1;
            end
            if (conv_is_buf) begin
              if (wr_ptr >= buf_length && !buf_wrap) begin
                buf_ovf_irq <= irq_ovf_en;
              end else begin
                fifo_push    <= 1'b1;
                fifo_in_data <= {(wr_ptr >= buf_length) ? {AWID{1'b0}} : wr_ptr,
                                 6'h00, conversion_result};
                if (wr_ptr + 1'b1 == {1'b0, buf_length[AWID-1:1]})
                  buf_half_irq <= irq_half_en;
                if (wr_ptr + 1'b1 == buf_length || wr_ptr >= buf_length) begin
                  buf_full_irq <= irq_full_en;
                  if (buf_wrap) wr_ptr <= {AWID{1'b0}};
                  else wr_ptr <= buf_length;
                end else begin
                  wr_ptr <= wr_ptr + 1'b1;
                end
              end
            end else if (continuous) begin
              run_req <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // adsb_ctrl

// ---- tb/adsb_ctrl_checker.sv ----
// assertion checker watching the converter sequencer ports
`timescale 1ns/10ps
`include "adsb_regs.vh"
module adsb_ctrl_checker #(
  parameter AWID = 11
) (
  // clock and reset
  input wire logic            clk,
  input wire logic            reset_n,
  // configuration seen by the checker
  input wire logic [1:0]      clk_div_sel,
  input wire logic [1:0]      sample_sel,
  input wire logic            gain_sel,
  input wire logic [AWID-1:0] buf_length,
  input wire logic [9:0]      monitor_upper_limit,
  input wire logic [9:0]      monitor_lower_limit,
  input wire logic [1:0]      monitor_mode,
  input wire logic            monitor_irq_en,
  // analog core side
  input wire logic            sample_hold,
  input wire logic            convert_active,
  input wire logic [2:0]      channel_sel,
  input wire logic            gain,
  input wire logic            supply_div_en,
  // dma port and events
  input wire logic            dma_valid,
  input wire logic            dma_ready,
  input wire logic [AWID-1:0] dma_addr,
  input wire logic [15:0]     dma_data,
  input wire logic [9:0]      conversion_result,
  input wire logic            conv_irq,
  input wire logic            monitor_irq
);
  // clk cycles spent in the current sample or convert phase
  logic [11:0] samp_cnt;
  logic [11:0] conv_cnt;
  // adc period in clk cycles and sample window in adc clocks
  wire  [11:0] adc_per = 12'h008 << clk_div_sel;
  wire  [11:0] s_per   = {9'h000, sample_sel, 1'b0} + 12'h002;
  // phase length counters
  always @(posedge clk) begin
    if (!reset_n) begin
      samp_cnt <= 12'h000;
      conv_cnt <= 12'h000;
    end else begin
      samp_cnt <= sample_hold ? samp_cnt + 12'h001 : 12'h000;
      conv_cnt <= convert_active ? conv_cnt + 12'h001 : 12'h000;
    end
  end
  // monitor condition, worked out independently of the design
  function automatic logic hit(input logic [1:0] md, input logic [9:0] v, input logic [9:0] up, input logic [9:0] lo);
    case (md)
      `ADSB_MON_BELOW: hit = v < lo;
      `ADSB_MON_ABOVE: hit = v > up;
      `ADSB_MON_INSIDE: hit = (v >= lo) && (v <= up);
      default: hit = (v < lo) || (v > up);
    endcase
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_samp_len: assert property ($fell(sample_hold) |-> samp_cnt == s_per * adc_per)
    else $error("sample window length wrong");
  chk_conv_len: assert property ($fell(convert_active) |-> conv_cnt == (s_per + s_per + 12'h00D) * adc_per)
    else $error("convert phase length wrong");
  chk_phase_excl: assert property (sample_hold |-> !convert_active)
    else $error("sample and convert overlap");
  chk_irq_pulse: assert property (conv_irq |=> !conv_irq)
    else $error("completion pulse too long");
  chk_dma_hold: assert property (dma_valid && !dma_ready |=> dma_valid && $stable(dma_addr) && $stable(dma_data))
    else $error("dma write changed while stalled");
  chk_dma_word: assert property (dma_valid |-> dma_data[15:10] == 6'h00)
    else $error("dma word upper bits set");
  chk_dma_bound: assert property (dma_valid |-> dma_addr < buf_length)
    else $error("dma write beyond buffer end");
  chk_supply_gate: assert property (supply_div_en |-> channel_sel == `ADSB_CH_SUPPLY)
    else $error("supply divider on for other channel");
  chk_gain_copy: assert property ($rose(sample_hold) |-> gain == gain_sel)
    else $error("gain not taken from setting");
  chk_mon_cond: assert property (monitor_irq |-> monitor_irq_en && hit(monitor_mode, conversion_result,
    monitor_upper_limit, monitor_lower_limit))
    else $error("monitor event without its condition");
endmodule // adsb_ctrl_checker
bind adsb_ctrl adsb_ctrl_checker #(.AWID(AWID)) u_chk (.clk, .reset_n, .clk_div_sel, .sample_sel, .gain_sel,
  .buf_length, .monitor_upper_limit, .monitor_lower_limit, .monitor_mode, .monitor_irq_en, .sample_hold,
  .convert_active, .channel_sel, .gain, .supply_div_en, .dma_valid, .dma_ready, .dma_addr, .dma_data,
  .conversion_result, .conv_irq, .monitor_irq);

// ---- tb/adsb_ram_model.sv ----
// stand-in for the analog core output and the ram behind the dma port
`timescale 1ns/10ps
module adsb_ram_model #(
  parameter AWID = 11
) (
  // clock and test controls
  input  wire logic            clk,
  input  wire logic            stall,
  input  wire logic [9:0]      level,
  // analog core
  output logic      [9:0]      analog_result,
  // dma write port
  input  wire logic            dma_valid,
  output logic                 dma_ready = 1'b0,
  input  wire logic [AWID-1:0] dma_addr,
  input  wire logic [15:0]     dma_data
);
  // stored words and accepted write count
  logic [15:0] mem [0:2047];
  int          n_wr = 0;
  // input held steady so the sampled value is known
  assign analog_result = level;
  // ready follows the stall request one cycle late, like a busy ram
  always @(posedge clk) begin
    dma_ready <= !stall;
    if (dma_valid === 1'b1 && dma_ready) begin
      mem[dma_addr] <= dma_data;
      n_wr <= n_wr + 1;
    end
  end
endmodule // adsb_ram_model

// ---- tb/adsb_ctrl_tb.sv ----
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "adsb_regs.vh"
module adsb_ctrl_tb;
  // clock, reset and test controls
  logic        clk = 1'b0, reset_n = 1'b0, start = 1'b0, stall = 1'b0, irq_en = 1'b1, sh_q = 1'b0;
  logic        gain_sel = 1'b0, continuous = 1'b0, acc_enable = 1'b0, acc_defer_irq = 1'b0;
  logic        buf_mode = 1'b0, buf_wrap = 1'b0;
  logic [1:0]  clk_div_sel = 2'h0, sample_sel = 2'h0, acc_count_sel = 2'h0, monitor_mode = 2'h0;
  logic [2:0]  single_channel = 3'h0;
  logic [9:0]  level = 10'h000, mon_up = 10'h200, mon_lo = 10'h100;
  logic [10:0] buf_len = 11'h006;
  // design outputs
  logic        sample_hold, convert_active, gain, supply_div_en, dma_valid, dma_ready, conv_done, conv_irq;
  logic        buf_half_irq, buf_full_irq, buf_ovf_irq, monitor_irq, monitor_output_pin, busy;
  logic [2:0]  channel_sel;
  logic [9:0]  analog_result, conversion_result;
  logic [10:0] dma_addr;
  logic [15:0] dma_data;
  logic [13:0] acc_sum;
  // tallies
  int          failures = 0, n_checks = 0, cyc = 0, n_mon = 0, n_half = 0, n_full = 0, n_ovf = 0, n_supply = 0;
  logic [2:0]  chq [$];
  adsb_ctrl DUT (.clk, .reset_n, .clk_div_sel, .sample_sel, .gain_sel, .continuous,
    .start, .acc_enable, .acc_count_sel, .acc_defer_irq, .single_channel, .buf_mode, .buf_channel_mask(8'h85),
    .trigger_period(16'h02FF), .buf_length(buf_len), .buf_wrap, .irq_half_en(irq_en), .irq_full_en(irq_en),
    .irq_ovf_en(irq_en), .monitor_upper_limit(mon_up), .monitor_lower_limit(mon_lo), .monitor_mode,
    .monitor_irq_en(irq_en), .monitor_pin_en(irq_en), .adc_clk(), .sample_hold, .convert_active, .channel_sel,
    .gain, .supply_div_en, .analog_result, .dma_valid, .dma_ready, .dma_addr, .dma_data, .conversion_result,
    .acc_sum, .conv_done, .conv_irq, .buf_half_irq, .buf_full_irq, .buf_ovf_irq, .monitor_irq,
    .monitor_output_pin, .busy);
  adsb_ram_model ram (.clk, .stall, .level, .analog_result, .dma_valid, .dma_ready, .dma_addr,
    .dma_data);
  // 8 ns clock
  initial forever #4 clk = ~clk;
  // event tallies and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (monitor_irq === 1'b1) n_mon <= n_mon + 1;
    if (buf_half_irq === 1'b1) n_half <= n_half + 1;
    if (buf_full_irq === 1'b1) n_full <= n_full + 1;
    if (buf_ovf_irq === 1'b1) n_ovf <= n_ovf + 1;
    if (supply_div_en === 1'b1) n_supply <= n_supply + 1;
    if (sample_hold === 1'b1 && sh_q !== 1'b1) chq.push_back(channel_sel);
    sh_q <= sample_hold;
    if (cyc == 30000) begin
      failures++;
      $display("Error at %0t: run hung", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one-cycle software start request
  task automatic go();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  // wait for a fresh completion pulse, bounded
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (conv_irq !== 1'b1 && n < 4000);
    // a completion that never comes counts against the run
    if (conv_irq !== 1'b1) begin
      failures++;
      $display("Error at %0t: no completion event", $time);
    end
  endtask
  // every division, window and monitor mode, boundary levels included
  task automatic t_single();
    int n, e, m0;
    logic [9:0] lv [4] = '{10'h0FF, 10'h200, 10'h100, 10'h201};
    logic [3:0] hit = 4'b1101;
    for (int i = 0; i < 4; i++) begin
      m0 = n_mon;
      e = (3 * (2 * i + 2) + 13) * (8 << i);
      @(posedge clk);
      clk_div_sel <= 2'(i);
      sample_sel <= 2'(i);
      monitor_mode <= 2'(i);
      gain_sel <= i[0];
      level <= lv[i];
      go();
      wait_irq(n);
      chk(n >= e && n <= e + (8 << i) + 3, 1'b1, "conversion time");
      chk(conversion_result, lv[i], "result");
      chk(conv_done, 1'b1, "done flag");
      repeat (2) @(negedge clk);
      chk(monitor_output_pin, hit[i], "monitor pin");
      chk(n_mon - m0, hit[i], "monitor events");
    end
  endtask
  task automatic t_supply();
    int n, s0;
    s0 = n_supply;
    @(posedge clk);
    single_channel <= `ADSB_CH_SUPPLY;
    clk_div_sel <= 2'h0;
    sample_sel <= 2'h0;
    go();
    @(negedge clk);
    chk(conv_done, 1'b0, "done cleared by start");
    wait_irq(n);
    repeat (2) @(negedge clk);
    chk(n_supply > s0, 1'b1, "divider used");
    chk(supply_div_en, 1'b0, "divider off after");
  endtask
  // continuous accumulation over four samples with deferred event
  task automatic t_accum();
    int n;
    @(posedge clk);
    single_channel <= 3'h1;
    acc_enable <= 1'b1;
    acc_count_sel <= 2'h1;
    acc_defer_irq <= 1'b1;
    continuous <= 1'b1;
    level <= 10'h2AB;
    go();
    wait_irq(n);
    chk(n >= 608 && n <= 680, 1'b1, "deferred event");
    chk(acc_sum, 14'h0AAC, "sum of four");
    @(posedge clk);
    level <= 10'h001;
    wait_irq(n);
    chk(acc_sum, 14'h0004, "sum restarts");
    @(posedge clk);
    continuous <= 1'b0;
    acc_enable <= 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk(conv_done, 1'b1, "done pollable");
  endtask
  // timer-driven buffer after a reset: stalled ram, then overflow or wrap
  task automatic t_buffer(input logic wrap);
    int w0, h0, f0, o0;
    @(posedge clk);
    reset_n <= 1'b0;
    buf_wrap <= wrap;
    irq_en <= !wrap;
    stall <= 1'b1;
    level <= 10'h3FF;
    repeat (5) @(posedge clk);
    w0 = ram.n_wr;
    h0 = n_half;
    f0 = n_full;
    o0 = n_ovf;
    chq.delete();
    reset_n <= 1'b1;
    buf_mode <= 1'b1;
    repeat (1500) @(posedge clk);
    stall <= 1'b0;
    level <= wrap ? 10'h0AA : 10'h3FF;
    repeat (1304) @(posedge clk);
    buf_mode <= 1'b0;
    @(negedge clk);
    chk(n_half - h0, !wrap, "half event");
    if (!wrap) begin
      chk(ram.n_wr - w0, 16'h0006, "words written");
      chk(n_ovf > o0, 1'b1, "overflow event");
      chk(n_full - f0, 16'h0001, "full event");
      chk(monitor_output_pin, 1'b1, "monitor pin in buffer mode");
      for (int k = 0; k < 6; k++) chk(ram.mem[k], 16'h03FF, "stored word");
      for (int k = 0; k < 6; k++) chk(chq[k], k % 3 == 0 ? 3'h0 : k % 3 == 1 ? 3'h2 : 3'h7, "scan order");
    end else begin
      chk(ram.n_wr - w0 >= 9 && (ram.n_wr - w0) % 3 == 0, 1'b1, "wrapped writes");
      chk(ram.mem[0], 16'h00AA, "word at start rewritten");
      chk(n_ovf - o0, 16'h0000, "masked overflow");
      chk(monitor_output_pin, 1'b0, "masked monitor pin");
    end
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_single();
    t_supply();
    t_accum();
    t_buffer(1'b0);
    t_buffer(1'b1);
    stop_test();
  end
endmodule // adsb_ctrl_tb
